// ### hdl/cdgc_regs.svh
// register offsets, field positions and reset values of the
// card-detect / general-control bank; included by the design files
`ifndef CDGC_REGS_SVH
`define CDGC_REGS_SVH

`define CDGC_ADDR_W 16
`define CDGC_DATA_W 32

// register indices; byte address is four times the index
`define CDGC_IDX_CARD_DET 12'h816
`define CDGC_IDX_GLOBAL 12'h81e
`define CDGC_IDX_IRQ_STAT 12'h8f0
`define CDGC_IDX_IRQ_MASK 12'h8f1
`define CDGC_IDX_CSC_CFG 12'h8f2

// card detect and general control fields
`define CDGC_BIT_SENSE2 7
`define CDGC_BIT_SENSE1 6
`define CDGC_BIT_SOFT_IRQ 5
`define CDGC_BIT_RESUME_EN 4
`define CDGC_BIT_REMOVAL_RST 1
`define CDGC_CARD_DET_WMASK 8'h12

// status-change interrupt configuration
`define CDGC_BIT_DET_IRQ_EN 3
`define CDGC_CSC_CFG_WMASK 8'h08

// global control: bits 7..5 read as zero
`define CDGC_GLOBAL_WMASK 8'h1f

// status / mask layout
`define CDGC_ST_CHANGE 0
`define CDGC_ST_REMOVED 1
`define CDGC_STAT_WMASK 8'h03

// reset values
`define CDGC_RST_CARD_DET 8'h00
`define CDGC_RST_GLOBAL 8'h00
`define CDGC_RST_IRQ_MASK 8'h00
`define CDGC_RST_CSC_CFG 8'h00

// axi responses
`define CDGC_RESP_OKAY 2'b00
`define CDGC_RESP_SLVERR 2'b10

`endif

// ### hdl/cdgc_pkg.sv
// types shared by the card-detect control bank
// assumes nothing of its surroundings
package cdgc_pkg;

  typedef enum logic [2:0] {
    CDGC_SEL_NONE = 3'h0,
    CDGC_SEL_CARD_DET = 3'h1,
    CDGC_SEL_GLOBAL = 3'h2,
    CDGC_SEL_IRQ_STAT = 3'h3,
    CDGC_SEL_IRQ_MASK = 3'h4,
    CDGC_SEL_CSC_CFG = 3'h5
  } cdgc_sel_t;

  // gray along idle -> one half taken -> response
  typedef enum logic [1:0] {
    CDGC_WS_IDLE = 2'b00,
    CDGC_WS_ADDR = 2'b01,
    CDGC_WS_RESP = 2'b11,
    CDGC_WS_DATA = 2'b10
  } cdgc_wstate_t;

  typedef enum logic {
    CDGC_RS_IDLE = 1'b0,
    CDGC_RS_RESP = 1'b1
  } cdgc_rstate_t;

endpackage

// ### hdl/cdgc_evt_if.sv
// signals between the top, the card-detect sampler and the resume latch
// all on aclk
`timescale 1ns/1ns
interface cdgc_evt_if;
  logic cd_change;
  logic card_removed;
  logic sense1;
  logic sense2;
  logic resume_en;
  logic csc_flag;
  logic ri_low;

  modport sampler (
    output cd_change,
    output card_removed,
    output sense1,
    output sense2
  );
  modport resume (
    input resume_en,
    input cd_change,
    input csc_flag,
    output ri_low
  );
  modport top (
    input cd_change,
    input card_removed,
    input sense1,
    input sense2,
    output resume_en,
    output csc_flag,
    input ri_low
  );
endinterface

// ### hdl/cdgc_detect.sv
// card-detect sampler: change and removal pulses, sense levels
// assumes card-detect and sense pins synchronous to aclk
`timescale 1ns/1ns
module cdgc_detect
  import cdgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic card_detect_1_n,
  input wire logic card_detect_2_n,
  input wire logic voltage_sense_1,
  input wire logic voltage_sense_2,
  cdgc_evt_if.sampler evt
);
  logic [1:0] cd_prev;
  logic primed;

  // no change is reported before one sample has been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    cd_prev <= {card_detect_2_n, card_detect_1_n};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt.cd_change <= 1'b0;
      evt.card_removed <= 1'b0;
    end else begin
      evt.cd_change <= primed &&
        (cd_prev != {card_detect_2_n, card_detect_1_n});
      // present was both low; any pin rising ends it
      evt.card_removed <= primed && (cd_prev == 2'b00) &&
        (card_detect_1_n || card_detect_2_n);
    end
  end

  // RULE1 live sense level
  // RULE2 live sense level
  always_ff @(posedge aclk) begin
    evt.sense1 <= voltage_sense_1;
    evt.sense2 <= voltage_sense_2;
  end
endmodule // cdgc_detect

// ### hdl/cdgc_resume.sv
// card-detect resume latch behind the ring-indicate pin
// assumes change pulse and status flag on aclk
`timescale 1ns/1ns
module cdgc_resume
  import cdgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  cdgc_evt_if.resume evt
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt.ri_low <= 1'b0;
    // RULE6 change drives low
    // RULE8 gated by enable
    end else if (evt.resume_en && evt.cd_change) begin
      evt.ri_low <= 1'b1;
    // RULE7 held until flag clear
    end else if (!evt.csc_flag) begin
      evt.ri_low <= 1'b0;
    end
  end
endmodule // cdgc_resume

// ### hdl/cdgc_top.sv
// Contract
// RULE1 - bit 7 reads the present level of voltage sense pin 2
// RULE2 - bit 6 reads the present level of voltage sense pin 1
// RULE3 - writing one to bit 5 with detect interrupt enabled raises change
// RULE4 - with detect interrupt disabled, writing bit 5 does nothing
// RULE5 - bit 5 always reads zero
// RULE6 - with resume enabled, a card-detect change pulls ring indicate low
// RULE7 - ring indicate stays low until the change flag is cleared
// RULE8 - resume enable resets to zero; when zero ring indicate is untouched
// RULE9 - removal reset enable resets compat registers on card removal
// RULE10 - bits 3 and 2 read zero
// RULE11 - bit 0 reads zero
// RULE12 - global control at index 81e, resets to all zero
// RULE13 - writes to read-only sense and reserved bits are ignored
//
// top of the card-detect / general-control bank with an axi4-lite slave
// assumes one clock aclk, synchronous active-low reset, pins synchronous
`timescale 1ns/1ns
`include "cdgc_regs.svh"
module cdgc_top
  import cdgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CDGC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`CDGC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CDGC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`CDGC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic card_detect_1_n,
  input wire logic card_detect_2_n,
  input wire logic voltage_sense_1,
  input wire logic voltage_sense_2,
  output logic irq,
  output logic ring_indicate_out_n,
  output logic compat_reset
);

  // address to register select; misaligned or out of range is none
  function automatic cdgc_sel_t reg_decode(
    input logic [`CDGC_ADDR_W-1:0] addr
  );
    logic [11:0] idx;
    cdgc_sel_t sel;
    idx = addr[13:2];
    sel = CDGC_SEL_NONE;
    if (addr[1:0] == 2'b00 && addr[15:14] == 2'b00) begin
      case (idx)
        `CDGC_IDX_CARD_DET: sel = CDGC_SEL_CARD_DET;
        `CDGC_IDX_GLOBAL: sel = CDGC_SEL_GLOBAL;
        `CDGC_IDX_IRQ_STAT: sel = CDGC_SEL_IRQ_STAT;
        `CDGC_IDX_IRQ_MASK: sel = CDGC_SEL_IRQ_MASK;
        `CDGC_IDX_CSC_CFG: sel = CDGC_SEL_CSC_CFG;
        default: sel = CDGC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // byte lane 0 merge under a write mask
  function automatic logic [7:0] merge_low(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] wmask,
    input logic lane_en
  );
    logic [7:0] res;
    res = old_val;
    if (lane_en) begin
      res = (old_val & ~wmask) | (new_val & wmask);
    end
    return res;
  endfunction

  cdgc_evt_if evt ();

  cdgc_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .card_detect_1_n(card_detect_1_n),
    .card_detect_2_n(card_detect_2_n),
    .voltage_sense_1(voltage_sense_1),
    .voltage_sense_2(voltage_sense_2),
    .evt(evt.sampler)
  );

  cdgc_resume u_resume (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt.resume)
  );

  // register state
  logic [7:0] card_det_ctrl;
  logic [7:0] socket_global_ctrl;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] csc_cfg;

  // write channel
  cdgc_wstate_t wstate;
  cdgc_wstate_t next_wstate;
  logic aw_hs;
  logic w_hs;
  logic [`CDGC_ADDR_W-1:0] aw_addr_q;
  logic [`CDGC_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [`CDGC_ADDR_W-1:0] wr_addr;
  logic [`CDGC_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  cdgc_sel_t wr_sel;
  logic [7:0] wr_byte;
  logic wr_lane;

  // read channel
  cdgc_rstate_t rstate;
  cdgc_rstate_t next_rstate;
  logic ar_hs;
  cdgc_sel_t rd_sel;
  logic [7:0] rd_byte;

  // event terms
  logic soft_detect_irq;
  logic removal_reset;
  logic [7:0] stat_set;
  logic [7:0] stat_clr;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_wstate = wstate;
    case (wstate)
      CDGC_WS_IDLE: begin
        if (aw_hs && w_hs) begin
          next_wstate = CDGC_WS_RESP;
        end else if (aw_hs) begin
          next_wstate = CDGC_WS_ADDR;
        end else if (w_hs) begin
          next_wstate = CDGC_WS_DATA;
        end
      end
      CDGC_WS_ADDR: begin
        if (w_hs) begin
          next_wstate = CDGC_WS_RESP;
        end
      end
      CDGC_WS_DATA: begin
        if (aw_hs) begin
          next_wstate = CDGC_WS_RESP;
        end
      end
      CDGC_WS_RESP: begin
        if (s_axi_bready) begin
          next_wstate = CDGC_WS_IDLE;
        end
      end
      default: next_wstate = CDGC_WS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= CDGC_WS_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      wstate <= next_wstate;
      s_axi_awready <= (next_wstate == CDGC_WS_IDLE) ||
                       (next_wstate == CDGC_WS_DATA);
      s_axi_wready <= (next_wstate == CDGC_WS_IDLE) ||
                      (next_wstate == CDGC_WS_ADDR);
      s_axi_bvalid <= (next_wstate == CDGC_WS_RESP);
    end
  end

  // hold whichever half arrives first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  assign wr_addr = aw_hs ? s_axi_awaddr : aw_addr_q;
  assign wr_data = w_hs ? s_axi_wdata : w_data_q;
  assign wr_strb = w_hs ? s_axi_wstrb : w_strb_q;
  assign do_write = (next_wstate == CDGC_WS_RESP) &&
                    (wstate != CDGC_WS_RESP);
  assign wr_sel = reg_decode(wr_addr);
  assign wr_byte = wr_data[7:0];
  assign wr_lane = wr_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `CDGC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= (wr_sel == CDGC_SEL_NONE) ? `CDGC_RESP_SLVERR :
                                                 `CDGC_RESP_OKAY;
    end
  end

  // RULE9 removal resets compat registers
  assign removal_reset = evt.card_removed &&
                         card_det_ctrl[`CDGC_BIT_REMOVAL_RST];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compat_reset <= 1'b0;
    end else begin
      compat_reset <= removal_reset;
    end
  end

  // RULE13 only resume and removal bits stored
  // RULE8 resume enable resets to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      card_det_ctrl <= `CDGC_RST_CARD_DET;
    end else if (removal_reset) begin
      card_det_ctrl <= `CDGC_RST_CARD_DET;
    end else if (do_write && wr_sel == CDGC_SEL_CARD_DET) begin
      card_det_ctrl <= merge_low(card_det_ctrl, wr_byte,
                                 `CDGC_CARD_DET_WMASK, wr_lane);
    end
  end

  // RULE12 global control resets to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      socket_global_ctrl <= `CDGC_RST_GLOBAL;
    end else if (removal_reset) begin
      socket_global_ctrl <= `CDGC_RST_GLOBAL;
    end else if (do_write && wr_sel == CDGC_SEL_GLOBAL) begin
      socket_global_ctrl <= merge_low(socket_global_ctrl, wr_byte,
                                      `CDGC_GLOBAL_WMASK, wr_lane);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csc_cfg <= `CDGC_RST_CSC_CFG;
    end else if (removal_reset) begin
      csc_cfg <= `CDGC_RST_CSC_CFG;
    end else if (do_write && wr_sel == CDGC_SEL_CSC_CFG) begin
      csc_cfg <= merge_low(csc_cfg, wr_byte, `CDGC_CSC_CFG_WMASK,
                           wr_lane);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `CDGC_RST_IRQ_MASK;
    end else if (do_write && wr_sel == CDGC_SEL_IRQ_MASK) begin
      irq_mask <= merge_low(irq_mask, wr_byte, `CDGC_STAT_WMASK,
                            wr_lane);
    end
  end

  // RULE3 soft write raises change
  // RULE4 no effect when disabled
  assign soft_detect_irq = do_write && wr_sel == CDGC_SEL_CARD_DET &&
                           wr_lane && wr_byte[`CDGC_BIT_SOFT_IRQ] &&
                           csc_cfg[`CDGC_BIT_DET_IRQ_EN];

  always_comb begin
    stat_set = 8'h00;
    stat_set[`CDGC_ST_CHANGE] = evt.cd_change || soft_detect_irq;
    stat_set[`CDGC_ST_REMOVED] = evt.card_removed;
  end

  always_comb begin
    stat_clr = 8'h00;
    if (do_write && wr_sel == CDGC_SEL_IRQ_STAT && wr_lane) begin
      stat_clr = wr_byte & `CDGC_STAT_WMASK;
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= (irq_status & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  assign evt.resume_en = card_det_ctrl[`CDGC_BIT_RESUME_EN];
  assign evt.csc_flag = irq_status[`CDGC_ST_CHANGE];

  // RULE7 pin follows resume latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_indicate_out_n <= 1'b1;
    end else begin
      ring_indicate_out_n <= !evt.ri_low;
    end
  end

  // read path
  always_comb begin
    next_rstate = rstate;
    case (rstate)
      CDGC_RS_IDLE: begin
        if (ar_hs) begin
          next_rstate = CDGC_RS_RESP;
        end
      end
      CDGC_RS_RESP: begin
        if (s_axi_rready) begin
          next_rstate = CDGC_RS_IDLE;
        end
      end
      default: next_rstate = CDGC_RS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= CDGC_RS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      rstate <= next_rstate;
      s_axi_arready <= (next_rstate == CDGC_RS_IDLE);
      s_axi_rvalid <= (next_rstate == CDGC_RS_RESP);
    end
  end

  assign rd_sel = reg_decode(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      CDGC_SEL_CARD_DET: begin
        // RULE5 soft bit reads zero
        // RULE10 bits 3..2 read zero
        // RULE11 bit 0 reads zero
        rd_byte = card_det_ctrl & `CDGC_CARD_DET_WMASK;
        // RULE1 sense 2 level
        rd_byte[`CDGC_BIT_SENSE2] = evt.sense2;
        // RULE2 sense 1 level
        rd_byte[`CDGC_BIT_SENSE1] = evt.sense1;
      end
      CDGC_SEL_GLOBAL: rd_byte = socket_global_ctrl;
      CDGC_SEL_IRQ_STAT: rd_byte = irq_status;
      CDGC_SEL_IRQ_MASK: rd_byte = irq_mask;
      CDGC_SEL_CSC_CFG: rd_byte = csc_cfg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= `CDGC_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (rd_sel == CDGC_SEL_NONE) ? `CDGC_RESP_SLVERR :
                                                 `CDGC_RESP_OKAY;
    end
  end

endmodule // cdgc_top

// ### tb/cdgc_card.sv
// card in the socket: detect and voltage-sense pins
// assumes the bench sets present and sense_code after aclk edges
`timescale 1ns/1ns
module cdgc_card (
  input wire logic aclk,
  input wire logic present,
  input wire logic [1:0] sense_code,
  output logic card_detect_1_n,
  output logic card_detect_2_n,
  output logic voltage_sense_1,
  output logic voltage_sense_2
);
  initial begin
    card_detect_1_n = 1'b1;
    card_detect_2_n = 1'b1;
    voltage_sense_1 = 1'b1;
    voltage_sense_2 = 1'b1;
  end
  // contacts make one cycle apart; open sense pins pull high
  always @(posedge aclk) begin
    card_detect_1_n <= !present;
    card_detect_2_n <= card_detect_1_n;
    voltage_sense_1 <= present ? sense_code[0] : 1'b1;
    voltage_sense_2 <= present ? sense_code[1] : 1'b1;
  end
endmodule // cdgc_card

// ### tb/cdgc_properties.sv
// concurrent checks on the ports of the card-detect bank
// assumes write address and data are offered in one cycle
`timescale 1ns/1ns
`include "cdgc_regs.svh"
module cdgc_properties
  import cdgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CDGC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [`CDGC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CDGC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`CDGC_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic card_detect_1_n,
  input wire logic card_detect_2_n,
  input wire logic voltage_sense_1,
  input wire logic voltage_sense_2,
  input wire logic irq,
  input wire logic ring_indicate_out_n,
  input wire logic compat_reset
);
  localparam logic [15:0] CD_A = 16'({`CDGC_IDX_CARD_DET, 2'h0});
  localparam logic [15:0] ST_A = 16'({`CDGC_IDX_IRQ_STAT, 2'h0});
  localparam logic [15:0] MK_A = 16'({`CDGC_IDX_IRQ_MASK, 2'h0});
  localparam logic [15:0] CF_A = 16'({`CDGC_IDX_CSC_CFG, 2'h0});
  logic wr_go, clr, det_en, rsm_en, rmv_en, mk_en;
  logic [15:0] ra;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_wstrb[0];
  assign clr = wr_go && s_axi_awaddr == ST_A && s_axi_wdata[0];
  // shadows of enables the ports cannot show
  always_ff @(posedge aclk) begin
    if (!aresetn || compat_reset) begin
      det_en <= 1'b0;
      rsm_en <= 1'b0;
      rmv_en <= 1'b0;
    end else if (wr_go && s_axi_awaddr == CD_A) begin
      rsm_en <= s_axi_wdata[`CDGC_BIT_RESUME_EN];
      rmv_en <= s_axi_wdata[`CDGC_BIT_REMOVAL_RST];
    end else if (wr_go && s_axi_awaddr == CF_A) begin
      det_en <= s_axi_wdata[`CDGC_BIT_DET_IRQ_EN];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mk_en <= 1'b0;
    end else if (wr_go && s_axi_awaddr == MK_A) begin
      mk_en <= s_axi_wdata[0];
    end
  end
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra <= s_axi_araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_cd;
    s_axi_rvalid && ra == CD_A && s_axi_rresp == `CDGC_RESP_OKAY;
  endsequence
  sequence pin_edge;
    $changed(card_detect_1_n) || $changed(card_detect_2_n);
  endsequence
  sequence soft_hit;
    wr_go && s_axi_awaddr == CD_A && s_axi_wdata[`CDGC_BIT_SOFT_IRQ];
  endsequence
  wr_answer_a: assert property (wr_go |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("upper read bits set");
  sense_read_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CD_A |=>
    s_axi_rdata[7] == $past(voltage_sense_2, 2) &&
    s_axi_rdata[6] == $past(voltage_sense_1, 2))
    else $error("sense level misread");
  soft_zero_a: assert property (rd_cd |-> !s_axi_rdata[5])
    else $error("soft interrupt bit read one");
  rsvd_zero_a: assert property (
    rd_cd |-> s_axi_rdata[3:2] == 2'h0 && !s_axi_rdata[0])
    else $error("reserved bits read one");
  soft_irq_a: assert property (
    soft_hit ##0 (det_en && mk_en) |-> ##[1:3] irq)
    else $error("soft interrupt missing");
  ring_fall_a: assert property (
    pin_edge ##0 rsm_en |-> ##3 !ring_indicate_out_n)
    else $error("ring indicate not pulled low");
  ring_hold_a: assert property (
    $rose(ring_indicate_out_n) |-> $past(clr, 3))
    else $error("ring indicate released early");
  ring_quiet_a: assert property (
    !rsm_en && ring_indicate_out_n |=> ring_indicate_out_n)
    else $error("ring indicate moved while disabled");
  removal_gate_a: assert property ($rose(compat_reset) |-> rmv_en)
    else $error("removal reset while disabled");
  pulse_one_a: assert property (compat_reset |=> !compat_reset)
    else $error("removal reset pulse too long");
endmodule // cdgc_properties

bind cdgc_top cdgc_properties u_cdgc_properties (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .card_detect_1_n, .card_detect_2_n,
  .voltage_sense_1, .voltage_sense_2, .irq, .ring_indicate_out_n,
  .compat_reset);

// ### tb/tb_card_detect_general_control.sv
// self-checking bench for the card-detect / general-control bank
// assumes the card model cdgc_card on the socket pins
`timescale 1ns/1ns
`include "cdgc_regs.svh"
module tb_card_detect_general_control
  import cdgc_pkg::*;
;
  localparam logic [15:0] A_CD = 16'({`CDGC_IDX_CARD_DET, 2'h0});
  localparam logic [15:0] A_GL = 16'({`CDGC_IDX_GLOBAL, 2'h0});
  localparam logic [15:0] A_ST = 16'({`CDGC_IDX_IRQ_STAT, 2'h0});
  localparam logic [15:0] A_MK = 16'({`CDGC_IDX_IRQ_MASK, 2'h0});
  localparam logic [15:0] A_CF = 16'({`CDGC_IDX_CSC_CFG, 2'h0});
  localparam logic [1:0] OK = `CDGC_RESP_OKAY;
  localparam logic [1:0] ER = `CDGC_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [`CDGC_ADDR_W-1:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [`CDGC_DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic card_detect_1_n, card_detect_2_n, voltage_sense_1, voltage_sense_2;
  logic irq, ring_indicate_out_n, compat_reset;
  logic present = 1'b1;
  logic [1:0] sense_code = 2'h2;
  int err_total = 0;
  int checks_done = 0;

  cdgc_top u_cdgc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .card_detect_1_n, .card_detect_2_n,
    .voltage_sense_1, .voltage_sense_2, .irq, .ring_indicate_out_n,
    .compat_reset);
  cdgc_card u_cdgc_card (.aclk, .present, .sense_code, .card_detect_1_n,
    .card_detect_2_n, .voltage_sense_1, .voltage_sense_2);

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic final_report();
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] resp);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b = 1'b0;
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(resp));
      end
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] resp);
    logic ar, r;
    ar = 1'b1;
    r = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (r) begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r = 1'b0;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, d});
        chk(32'(s_axi_rresp), 32'(resp));
      end
    end
  endtask

  task automatic t_defaults();
    rd(A_CD, 8'h80, OK);
    rd(A_GL, 8'h00, OK);
    rd(A_CF, 8'h00, OK);
    rd(A_MK, 8'h00, OK);
  endtask

  task automatic t_fields();
    wr(A_CD, 8'hff, OK);
    rd(A_CD, 8'h92, OK);
    wr(A_CD, 8'h00, OK);
    wr(A_GL, 8'hff, OK);
    rd(A_GL, 8'h1f, OK);
    wr(16'h2000, 8'h55, ER);
    rd(16'h2000, 8'h00, ER);
    rd(A_CD | 16'h1, 8'h00, ER);
  endtask

  task automatic t_sense();
    for (int i = 0; i < 4; i++) begin
      sense_code <= 2'(i);
      repeat (3) @(posedge aclk);
      rd(A_CD, {2'(i), 6'h0}, OK);
    end
  endtask

  task automatic t_soft();
    wr(A_CD, 8'h20, OK);
    rd(A_ST, 8'h00, OK);
    wr(A_CF, 8'h08, OK);
    wr(A_MK, 8'h00, OK);
    wr(A_CD, 8'h20, OK);
    rd(A_ST, 8'h01, OK);
    chk(32'(irq), 32'h0);
    wr(A_MK, 8'h01, OK);
    rd(A_MK, 8'h01, OK);
    chk(32'(irq), 32'h1);
    wr(A_ST, 8'h01, OK);
    rd(A_ST, 8'h00, OK);
    chk(32'(irq), 32'h0);
    wr(A_CD, 8'h20, OK);
    rd(A_ST, 8'h01, OK);
    chk(32'(irq), 32'h1);
    wr(A_ST, 8'h01, OK);
    rd(A_ST, 8'h00, OK);
  endtask

  task automatic t_resume();
    present <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(compat_reset), 32'h0);
    repeat (4) @(posedge aclk);
    chk(32'(ring_indicate_out_n), 32'h1);
    rd(A_ST, 8'h03, OK);
    rd(A_GL, 8'h1f, OK);
    wr(A_ST, 8'h03, OK);
    wr(A_CD, 8'h10, OK);
    present <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(ring_indicate_out_n), 32'h0);
    rd(A_ST, 8'h01, OK);
    chk(32'(ring_indicate_out_n), 32'h0);
    wr(A_ST, 8'h01, OK);
    repeat (3) @(posedge aclk);
    chk(32'(ring_indicate_out_n), 32'h1);
  endtask

  task automatic t_removal();
    wr(A_CD, 8'h02, OK);
    present <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(compat_reset), 32'h1);
    repeat (4) @(posedge aclk);
    rd(A_GL, 8'h00, OK);
    rd(A_CD, 8'hc0, OK);
    rd(A_CF, 8'h00, OK);
  endtask

  initial begin
    #(20000 * 50);
    err_total++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_fields();
    t_sense();
    t_soft();
    t_resume();
    t_removal();
    final_report();
  end
endmodule // tb_card_detect_general_control
